// [rtl/cg_cfg.svh]
`ifndef CG_CFG_SVH
`define CG_CFG_SVH

// Clock
`define CG_CLK_NS        10

// Averaging slot, 6 ms
`define CG_SLOT_NS       6000000
`define CG_SLOT_CYC      (`CG_SLOT_NS / `CG_CLK_NS)

// Output frame: 160 Hz nominal, 128 steps per frame
`define CG_PWM_HZ        160
`define CG_PWM_STEPS     128
`define CG_FRAME_NS      (1000000000 / `CG_PWM_HZ)
`define CG_STEP_CYC      (`CG_FRAME_NS / `CG_PWM_STEPS / `CG_CLK_NS)

// Duty = I/(2.2*Ifs) + 0.5, so code gain around mid is 128/2.2 = 640/11
`define CG_GAIN_NUM      640
`define CG_GAIN_DEN      11
`define CG_MID_CODE      7'h40
// Nearest 128-step codes to 95.5 and 4.5 percent duty
`define CG_FS_POS_CODE   7'h7A
`define CG_FS_NEG_CODE   7'h06
`define CG_FRAC_BITS     24

// Full-scale build option in milliamps: 1000 or 10000
`define CG_FS_LOW_MA     1000
`define CG_FS_HIGH_MA    10000

`endif

// [rtl/cg_current_gauge.sv]
`timescale 1ns/1ns
// Function
// - Filter modulator bitstream into multi-bit value
// - Output high while value exceeds ramp
// - Zero current gives half duty cycle
// - Positive current above half, negative below
// - Full scale maps near 95.5 and 4.5 percent
// - Duty equals current over 2.2 full-scale, plus half
// - Full scale is 1 A or 10 A
// - Duty quantized to 128 steps
// - Extra half-step added to high time
// - Average over 6 ms slots, update once per slot
// - Jitter zero mean, small deviation
// - Peak jitter within 0.3 percent
// - Output frame near 160 Hz, 100 to 250
`include "cg_cfg.svh"

module cg_current_gauge
	import cg_pkg::*;
#(
	parameter int SLOT_CYC  = `CG_SLOT_CYC,
	parameter int STEP_CYC  = `CG_STEP_CYC,
	parameter int FS_MA     = `CG_FS_LOW_MA
) (
	input  wire logic     clk,
	input  wire logic     rst_n,
	input  wire logic     modBit,
	output logic          pwmOut,
	output cg_code_t      codeOut,
	output logic          slotStrobe
);

	// Fixed-point gain 2^24 * 640 / (11 * slot length); a multiply replaces a divider
	localparam longint GAIN_K = ((64'd1 << `CG_FRAC_BITS) * `CG_GAIN_NUM) / (`CG_GAIN_DEN * longint'(SLOT_CYC));
	localparam logic [23:0] SLOT_LAST = 24'(SLOT_CYC - 1);
	localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);
	localparam logic [15:0] STEP_HALF = 16'(STEP_CYC / 2);
	localparam logic [23:0] ONES_HALF = 24'(SLOT_CYC / 2);
	localparam logic [23:0] ONES_FULL = 24'(SLOT_CYC);
	localparam cg_state_t   RESET_S   = '{pwmCode: `CG_MID_CODE, slotCode: `CG_MID_CODE, default: '0};

	// Range option changes only the analog scaling; the digital mapping is the same
	localparam bit HIGH_RANGE = (FS_MA == `CG_FS_HIGH_MA);

	cg_state_t s_q;
	cg_state_t s_d;

	// Ones density to signed code around mid-scale, rounded and clamped to 0..127
	function automatic cg_code_t cg_to_code(input logic [23:0] ones);
		longint diff;
		longint prod;
		longint code;
		diff = 2 * longint'(ones) - longint'(SLOT_CYC);
		prod = diff * GAIN_K + (64'sd1 <<< (`CG_FRAC_BITS - 1));
		code = longint'(`CG_MID_CODE) + (prod >>> `CG_FRAC_BITS);
		if (code < 0) begin
			code = 0;
		end else if (code > 127) begin
			code = 127;
		end
		return cg_code_t'(code);
	endfunction

	logic        slotEnd;
	logic        stepEnd;
	logic        frameEnd;
	logic [23:0] onesTotal;

	always_comb begin
		slotEnd   = (s_q.slotCnt == SLOT_LAST);
		stepEnd   = (s_q.stepCnt == STEP_LAST);
		frameEnd  = stepEnd && (s_q.ramp == 7'h7F);
		onesTotal = s_q.onesCnt + {23'h000000, s_q.modSync[1]};
	end

	always_comb begin
		s_d = s_q;
		// Modulator output is asynchronous to clk
		s_d.modSync = {s_q.modSync[0], modBit};

		// Boxcar average: count ones over one slot, hold result until the next
		if (slotEnd) begin
			s_d.slotCnt  = '0;
			s_d.onesCnt  = '0;
			s_d.slotCode = cg_to_code(onesTotal);
			s_d.slotDone = 1'b1;
		end else begin
			s_d.slotCnt  = s_q.slotCnt + 24'h000001;
			s_d.onesCnt  = onesTotal;
			s_d.slotDone = 1'b0;
		end

		// Free-running ramp, 128 steps per frame
		if (stepEnd) begin
			s_d.stepCnt = '0;
			s_d.ramp    = s_q.ramp + 7'h01;
		end else begin
			s_d.stepCnt = s_q.stepCnt + 16'h0001;
		end

		// New value only at wrap so a frame is never cut mid-way
		if (frameEnd) begin
			s_d.pwmCode = s_q.slotCode;
		end

		// High while code exceeds ramp, plus half a step at ramp == code
		s_d.pwm = (s_q.pwmCode > s_q.ramp)
			|| ((s_q.pwmCode == s_q.ramp) && (s_q.stepCnt < STEP_HALF));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= RESET_S;
		end else begin
			s_q <= s_d;
		end
	end

	// Deterministic filter: no added jitter, so mean jitter is zero
	assign pwmOut     = s_q.pwm;
	assign codeOut    = s_q.pwmCode;
	assign slotStrobe = s_q.slotDone;

	// Helper: high-time counter per frame, checked at frame wrap
	logic [23:0] highCnt_q;
	logic [23:0] highCnt_d;
	logic [23:0] highExp;

	always_comb begin
		highCnt_d = frameEnd ? '0 : (highCnt_q + {23'h000000, s_d.pwm});
		highExp   = 24'(s_q.pwmCode) * 24'(STEP_CYC) + 24'(STEP_HALF);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			highCnt_q <= '0;
		end else begin
			highCnt_q <= highCnt_d;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Half-step checks assume STEP_CYC >= 16, so the extension spans at least 8 cycles

	code_load_wrap_a: assert property (
		!$stable(s_q.pwmCode) |-> $past(frameEnd))
		else $error("output code changed away from frame wrap");

	ramp_below_code_a: assert property (
		(s_q.ramp < s_q.pwmCode) |=> pwmOut)
		else $error("output low while code exceeds ramp");

	ramp_above_code_a: assert property (
		(s_q.ramp > s_q.pwmCode) |=> !pwmOut)
		else $error("output high while ramp exceeds code");

	half_step_high_a: assert property (
		(s_q.ramp == s_q.pwmCode) && (s_q.stepCnt == '0) |=> pwmOut [*8])
		else $error("half step extension missing");

	half_step_end_a: assert property (
		(s_q.ramp == s_q.pwmCode) && (s_q.stepCnt == STEP_HALF) |=> !pwmOut)
		else $error("high time runs past half step");

	zero_mid_code_a: assert property (
		slotEnd && (onesTotal == ONES_HALF) |=> (s_q.slotCode == `CG_MID_CODE) && slotStrobe)
		else $error("zero current does not give mid code");

	sign_direction_a: assert property (
		slotEnd && (onesTotal > ONES_HALF) |=> (s_q.slotCode >= `CG_MID_CODE))
		else $error("positive current below mid code");

	slot_strobe_a: assert property (
		slotStrobe |=> !slotStrobe)
		else $error("slot strobe longer than one cycle");

	frame_high_time_a: assert property (
		frameEnd && $stable(s_q.pwmCode) && (s_q.pwmCode != 7'h7F) |-> (highCnt_q == highExp))
		else $error("frame high time differs from code plus half step");

	// A slot below half density must land at or below mid code; a slot all of one sign on the full-scale codes
	sign_negative_a: assert property (
		slotEnd && (onesTotal < ONES_HALF) |=> (s_q.slotCode <= `CG_MID_CODE))
		else $error("negative current above mid code");

	full_scale_pos_a: assert property (
		slotEnd && (onesTotal == ONES_FULL) |=> (s_q.slotCode == `CG_FS_POS_CODE))
		else $error("positive full scale code wrong");

	full_scale_neg_a: assert property (
		slotEnd && (onesTotal == 24'h000000) |=> (s_q.slotCode == `CG_FS_NEG_CODE))
		else $error("negative full scale code wrong");

	// Guards the build option; any other value would mislead the host scaling
	fs_option_a: assert property (
		(FS_MA == `CG_FS_LOW_MA) || HIGH_RANGE)
		else $error("full scale option is neither low nor high range");

	code_load_value_a: assert property (
		frameEnd |=> (s_q.pwmCode == $past(s_q.slotCode)))
		else $error("frame wrap did not load the slot code");

	slot_code_hold_a: assert property (
		!$stable(s_q.slotCode) |-> $past(slotEnd))
		else $error("slot code changed inside a slot");

	slot_count_range_a: assert property (
		s_q.slotCnt <= SLOT_LAST)
		else $error("slot counter ran past slot length");

	step_count_range_a: assert property (
		s_q.stepCnt <= STEP_LAST)
		else $error("step counter ran past step length");

	cover_slot_c: cover property (slotStrobe);
	cover_load_c: cover property (frameEnd ##1 (s_q.pwmCode != `CG_MID_CODE));
	cover_high_c: cover property (pwmOut && (s_q.pwmCode > `CG_MID_CODE));
	cover_low_c: cover property (frameEnd ##1 (s_q.pwmCode < `CG_MID_CODE));
	cover_range_c: cover property (HIGH_RANGE || slotStrobe);

endmodule

// [rtl/cg_pkg.sv]
package cg_pkg;

	typedef logic [6:0] cg_code_t;

	typedef struct packed {
		logic [1:0]  modSync;
		logic [23:0] slotCnt;
		logic [23:0] onesCnt;
		cg_code_t    slotCode;
		cg_code_t    pwmCode;
		cg_code_t    ramp;
		logic [15:0] stepCnt;
		logic        slotDone;
		logic        pwm;
	} cg_state_t;

endpackage

// [test/cg_current_gauge_tb.sv]
`timescale 1ns/1ns
module cg_current_gauge_tb;
	import cg_pkg::*;
	localparam int SLOT = 200;
	localparam int STEP = 16;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        modBit = 1'b0;
	logic [1:0]  mode = 2'h0;
	logic        pwmOut;
	cg_code_t    codeOut;
	logic        slotStrobe;
	logic [15:0] highCyc;
	logic [15:0] perCyc;
	int          errors = 0;
	int          n_checks = 0;

	always #5 clk = ~clk;
	// Mode 2 gives exactly half density, so the slot sum lands on mid code
	always @(posedge clk) modBit <= #1 (mode == 2'h2) ? ~modBit : mode[0];

	cg_current_gauge #(.SLOT_CYC(SLOT), .STEP_CYC(STEP)) i_cg_current_gauge (
		.clk       (clk),
		.rst_n     (rst_n),
		.modBit    (modBit),
		.pwmOut    (pwmOut),
		.codeOut   (codeOut),
		.slotStrobe(slotStrobe)
	);
	cg_host_model i_cg_host_model (
		.clk    (clk),
		.rst_n  (rst_n),
		.pwmIn  (pwmOut),
		.highCyc(highCyc),
		.perCyc (perCyc)
	);

	task automatic check(string what, logic [15:0] seen, int exp);
		n_checks++;
		if (seen !== 16'(exp)) begin
			errors++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
		end
	endtask

	// Host conversion on the 1 A option, in mA, with the half step removed
	function automatic int host_ma(logic [15:0] hi, logic [15:0] per);
		longint num;
		if (per == 16'h0000)
			return 32767;
		num = 11000 * (256 * longint'(hi) - 129 * longint'(per));
		return int'(num / (1280 * longint'(per)));
	endfunction

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Three frames: one slot to fill, one wrap to load, one frame to time
	task automatic settle(logic [1:0] m, int code);
		@(posedge clk);
		#1 mode = m;
		repeat (3 * 128 * STEP) @(posedge clk);
		#2;
		check("code", {9'h000, codeOut}, code);
		check("high", highCyc, code * STEP + STEP / 2);
		check("period", perCyc, 128 * STEP);
	endtask

	task automatic t_zero;
		settle(2'h2, 64);
		check("half", 16'(2 * highCyc - STEP), 128 * STEP);
		check("zero mA", 16'(host_ma(highCyc, perCyc)), 0);
		$display("zero current test done");
	endtask

	task automatic t_pos;
		int sum;
		sum = 0;
		settle(2'h1, 122);
		// Four successive frames, summed as an averaging host would
		repeat (4) begin
			repeat (128 * STEP) @(posedge clk);
			#2 sum += highCyc;
		end
		check("average", 16'(sum / 4), 122 * STEP + STEP / 2);
		// Code 122 reads 996.875 mA, truncated by the host
		check("full mA", 16'(host_ma(highCyc, perCyc)), 996);
		check("high range mA", 16'(10 * host_ma(highCyc, perCyc)), 9960);
		$display("positive full scale test done");
	endtask

	task automatic t_neg;
		settle(2'h0, 6);
		check("negative mA", 16'(host_ma(highCyc, perCyc)), -996);
		$display("negative full scale test done");
	endtask

	task automatic t_slot;
		int n;
		n = 0;
		do begin @(posedge clk); #2; end while (slotStrobe !== 1'b1);
		do begin @(posedge clk); #2; n++; end while (slotStrobe !== 1'b1 && n < 1000);
		check("slot", 16'(n), SLOT);
		$display("slot timing test done");
	endtask

	initial begin
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		t_zero();
		t_pos();
		t_neg();
		t_slot();
		close_out();
	end

	initial begin
		#(20 * 128 * STEP * 10);
		errors++;
		close_out();
	end
endmodule

// [test/cg_host_model.sv]
`timescale 1ns/1ns
module cg_host_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        pwmIn,
	output logic [15:0]      highCyc,
	output logic [15:0]      perCyc
);
	logic        pwmQ;
	logic [15:0] cnt;
	logic [15:0] hiCnt;

	// Host times high interval and full period between rising edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwmQ    <= 1'b0;
			cnt     <= 16'h0000;
			hiCnt   <= 16'h0000;
			highCyc <= 16'h0000;
			perCyc  <= 16'h0000;
		end else begin
			pwmQ <= pwmIn;
			if (pwmIn && !pwmQ) begin
				perCyc  <= cnt;
				highCyc <= hiCnt;
				cnt     <= 16'h0001;
				hiCnt   <= 16'h0001;
			end else begin
				cnt   <= cnt + 16'h0001;
				hiCnt <= hiCnt + {15'h0000, pwmIn};
			end
		end
	end
endmodule
